// *** bench/otp_memory_model.sv ***
// Behavioural model of the 64K x 16 one-time programmable memory
`timescale 1ns/100ps
module otp_memory_model #(
   parameter logic [15:0] MAKER_CODE = 16'h0042,
   parameter logic [15:0] TYPE_CODE = 16'h0037
) (
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_data,
   input wire logic i_data_oe_n,
   input wire logic i_chip_select_n,
   input wire logic i_output_enable_n,
   input wire logic i_program_strobe_n,
   input wire logic i_vcc_prog,
   input wire logic i_vpp_prog,
   input wire logic i_id_select_line,
   output logic [15:0] o_data
);
   // Both identity codes are arbitrary values, upper byte zero
   logic [15:0] arr [0:65535];
   logic [15:0] float_val;
   initial begin
      for (int a = 0; a < 65536; a++) arr[a] = 16'hFFFF;
      float_val = 16'h5AA5;
   end
   // Cells only ever clear bits, and only with both supplies raised
   always @(posedge i_program_strobe_n) begin
      if (!i_chip_select_n && i_vpp_prog && i_vcc_prog && !i_data_oe_n) arr[i_addr] = arr[i_addr] & i_data;
   end
   // A released bus shows the inverse so a stale read cannot look correct
   always @(posedge i_output_enable_n) float_val = ~arr[i_addr];
   always @* begin
      if (!i_chip_select_n && !i_output_enable_n) o_data = i_id_select_line ? (i_addr[0] ? TYPE_CODE : MAKER_CODE) : arr[i_addr];
      else o_data = float_val;
   end
endmodule : otp_memory_model

// *** bench/otp_prog_checker_sva.sv ***
// Concurrent checks on the programmer's pin sequencing
`timescale 1ns/100ps
module otp_prog_checker (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [15:0] o_mem_addr,
   input wire logic [15:0] o_mem_data,
   input wire logic o_mem_data_oe_n,
   input wire logic o_chip_select_n,
   input wire logic o_output_enable_n,
   input wire logic o_program_strobe_n,
   input wire logic o_vcc_prog,
   input wire logic o_vpp_prog,
   input wire logic o_id_select_line,
   input wire logic o_done,
   input wire logic o_pass,
   input wire logic o_fail
);
   logic [15:0] low_r;
   logic [9:0] vcc_r;
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_arst_n);
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) low_r <= 16'h0000;
      else if (!o_program_strobe_n) low_r <= low_r + 16'h0001;
      else low_r <= 16'h0000;
   end
   // Saturates so a long session cannot wrap below the setup figure
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) vcc_r <= 10'h000;
      else if (!o_vcc_prog) vcc_r <= 10'h000;
      else if (vcc_r != 10'h3FF) vcc_r <= vcc_r + 10'h001;
   end
   a_strobe_width_ok: assert property ($rose(o_program_strobe_n) |-> low_r >= 16'h251C && low_r <= 16'h2904)
      else $error("program strobe width outside 95 to 105 us");
   a_vpp_needs_vcc: assert property (o_vpp_prog |-> o_vcc_prog)
      else $error("program voltage raised without core supply");
   a_vcc_lead_time: assert property ($rose(o_vpp_prog) |-> vcc_r >= 10'h0C7)
      else $error("core supply setup too short");
   a_strobe_powered: assert property (!o_program_strobe_n |-> o_vpp_prog && !o_chip_select_n && !o_mem_data_oe_n)
      else $error("strobe without supplies, select or data");
   a_verify_read: assert property (!o_output_enable_n |-> o_program_strobe_n && !o_chip_select_n && o_mem_data_oe_n)
      else $error("verify read with strobe or data drive");
   a_strobe_holds_word: assert property (!o_program_strobe_n && !$past(o_program_strobe_n) |-> $stable(o_mem_addr) && $stable(o_mem_data))
      else $error("address or data moved under the strobe");
   a_float_release: assert property ($rose(o_output_enable_n) |-> o_mem_data_oe_n [*8])
      else $error("data driven before the bus floated");
   a_session_start: assert property ($rose(o_vpp_prog) |-> o_mem_addr == 16'h0000)
      else $error("session not started at the first address");
   a_id_never: assert property (!o_id_select_line)
      else $error("id select line raised");
   a_one_verdict: assert property (o_done |-> o_pass != o_fail)
      else $error("done without a single verdict");
   c_power: cover property ($rose(o_vpp_prog));
   c_strobe: cover property ($fell(o_program_strobe_n));
   c_verify: cover property ($fell(o_output_enable_n));
   c_done: cover property ($rose(o_done));
endmodule : otp_prog_checker

bind otp_word_program_sequencer otp_prog_checker u_chk (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n),
   .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_mem_data_oe_n(o_mem_data_oe_n),
   .o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
   .o_program_strobe_n(o_program_strobe_n), .o_vcc_prog(o_vcc_prog), .o_vpp_prog(o_vpp_prog),
   .o_id_select_line(o_id_select_line), .o_done(o_done), .o_pass(o_pass), .o_fail(o_fail));

// *** bench/otp_word_program_sequencer_bench.sv ***
// Testbench for the programmer: reset, source buffer, power-up and the first three words of the first pass
`timescale 1ns/100ps
module otp_word_program_sequencer_bench;
   import otp_prog_pkg::*;
   logic i_clk_sys = 1'b0;
   logic i_arst_n = 1'b0;
   logic i_start = 1'b0;
   logic [15:0] i_src_data = 16'h0000;
   logic i_src_valid = 1'b0;
   logic feed_on = 1'b0;
   logic [15:0] mem_q, o_mem_addr, o_mem_data;
   logic o_src_ready, o_mem_data_oe_n, o_chip_select_n, o_output_enable_n, o_program_strobe_n;
   logic o_vcc_prog, o_vpp_prog, o_id_select_line, o_busy, o_done, o_pass, o_fail;
   int miscompares = 0, checks = 0, cyc = 0, fed = 0;

   otp_word_program_sequencer dut (.i_clk_sys(i_clk_sys), .i_arst_n(i_arst_n), .i_start(i_start),
      .i_src_data(i_src_data), .i_src_valid(i_src_valid), .o_src_ready(o_src_ready), .i_mem_data(mem_q),
      .o_mem_addr(o_mem_addr), .o_mem_data(o_mem_data), .o_mem_data_oe_n(o_mem_data_oe_n),
      .o_chip_select_n(o_chip_select_n), .o_output_enable_n(o_output_enable_n),
      .o_program_strobe_n(o_program_strobe_n), .o_vcc_prog(o_vcc_prog), .o_vpp_prog(o_vpp_prog),
      .o_id_select_line(o_id_select_line), .o_busy(o_busy), .o_done(o_done), .o_pass(o_pass), .o_fail(o_fail));
   otp_memory_model u_mem (.i_addr(o_mem_addr), .i_data(o_mem_data), .i_data_oe_n(o_mem_data_oe_n),
      .i_chip_select_n(o_chip_select_n), .i_output_enable_n(o_output_enable_n),
      .i_program_strobe_n(o_program_strobe_n), .i_vcc_prog(o_vcc_prog), .i_vpp_prog(o_vpp_prog),
      .i_id_select_line(o_id_select_line), .o_data(mem_q));

   always #5 i_clk_sys = ~i_clk_sys;

   function automatic logic [15:0] img(input logic [15:0] k);
      return 16'hC3A5 ^ {k[7:0], k[7:0]};
   endfunction : img

   task cmp(input logic [31:0] exp, input logic [31:0] got);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED time=%0t exp=%h got=%h", $time, exp, got);
      end
   endtask : cmp

   task results;
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : results

   // Ready only moves on a rising edge, so its value here is what that edge sees
   always @(negedge i_clk_sys) begin
      if (feed_on) begin
         i_src_data = img(fed[15:0]);
         i_src_valid = 1'b1;
         if (o_src_ready === 1'b1) fed = fed + 1;
      end
   end

   always @(posedge i_clk_sys) begin
      cyc++;
      if (cyc == 32'h0000_EA60) begin
         miscompares++;
         results();
      end
   end

   task t_reset;
      cmp(32'h0000_00F0, {24'h000000, o_program_strobe_n, o_chip_select_n, o_output_enable_n, o_mem_data_oe_n,
         o_vcc_prog, o_vpp_prog, o_busy, o_done});
   endtask : t_reset

   // The sequencer never pops while idle, so the buffer fills to its 32 words; the check also accepts 33
   task t_fill;
      feed_on = 1'b1;
      repeat (40) @(negedge i_clk_sys);
      cmp(32'h0000_0001, (fed >= 32 && fed <= 33));
      cmp(32'h0000_0000, o_src_ready);
   endtask : t_fill

   task t_power;
      int n;
      n = 0;
      i_start = 1'b1;
      while (o_vcc_prog !== 1'b1 && n < 50) begin
         @(negedge i_clk_sys);
         n++;
      end
      cmp(32'h0000_0001, o_vcc_prog);
      cmp(32'h0000_0000, o_vpp_prog);
      n = 0;
      while (o_vpp_prog !== 1'b1 && n < 400) begin
         @(negedge i_clk_sys);
         n++;
      end
      cmp(32'h0000_00C9, n);
      cmp(32'h0000_0000, o_mem_addr);
      cmp(32'h0000_0001, o_busy);
      cmp(32'h0000_0000, o_id_select_line);
   endtask : t_power

   task t_words;
      int n, w;
      logic oe_seen;
      for (int k = 0; k < 3; k++) begin
         n = 0;
         w = 0;
         oe_seen = 1'b0;
         while (o_program_strobe_n !== 1'b0 && n < 1000) begin
            @(negedge i_clk_sys);
            n++;
            oe_seen = oe_seen | !o_output_enable_n;
         end
         cmp(k, o_mem_addr);
         cmp(img(k[15:0]), o_mem_data);
         while (o_program_strobe_n === 1'b0 && w < 20000) begin
            @(negedge i_clk_sys);
            w++;
            oe_seen = oe_seen | !o_output_enable_n;
         end
         cmp(32'h0000_2710, w);
         cmp(32'h0000_0000, oe_seen);
         cmp(img(k[15:0]), u_mem.arr[k]);
      end
   endtask : t_words

   // A full session is hundreds of millions of cycles, so only its opening is run
   initial begin
      repeat (4) @(negedge i_clk_sys);
      i_arst_n = 1'b1;
      @(negedge i_clk_sys);
      t_reset();
      t_fill();
      t_power();
      t_words();
      results();
   end
endmodule : otp_word_program_sequencer_bench

// *** rtl/otp_prog_defines.svh ***
// Timing and limit constants for the one-time programmable memory programmer
`ifndef OTP_PROG_DEFINES_SVH
`define OTP_PROG_DEFINES_SVH
`define CLK_PERIOD_NS 10
`define STROBE_WIDTH_US 100
`define STROBE_CYC ((`STROBE_WIDTH_US * 1000) / `CLK_PERIOD_NS)
`define SETUP_US 2
`define SETUP_CYC (((`SETUP_US * 1000) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUTPUT_VALID_DELAY_NS 150
`define OUTPUT_VALID_CYC ((`OUTPUT_VALID_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define OUTPUT_FLOAT_DELAY_NS 130
`define OUTPUT_FLOAT_CYC ((`OUTPUT_FLOAT_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Read data passes two synchroniser flops, so every sample waits this much longer
`define SYNC_CYC 2
`define MAX_RETRY 4'h A
`define ADDR_FIRST 16'h0000
`define ADDR_LAST 16'hFFFF
`define TIMER_W 24
`define FIFO_DEPTH 32
`endif

// *** rtl/otp_prog_pkg.sv ***
// Types shared by the programmer design
package otp_prog_pkg;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0000,
      ST_PWR_VCC = 4'b0001,
      ST_PWR_VPP = 4'b0010,
      ST_P1_SETUP = 4'b0011,
      ST_P1_STROBE = 4'b0100,
      ST_P1_HOLD = 4'b0101,
      ST_VF_OE = 4'b0110,
      ST_VF_FLOAT = 4'b0111,
      ST_VF_STROBE = 4'b1000,
      ST_PWR_DOWN = 4'b1001,
      ST_RB_OE = 4'b1010,
      ST_RB_FLOAT = 4'b1011,
      ST_DONE = 4'b1100
   } prog_state_t;
   typedef enum logic [1:0] {
      PASS_ONE = 2'b00,
      PASS_VERIFY = 2'b01,
      PASS_READBACK = 2'b10
   } pass_t;
endpackage : otp_prog_pkg

// *** rtl/otp_word_fifo.sv ***
// Synchronous valid/ready FIFO with parameterised width and depth
`timescale 1ns/100ps
module otp_word_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 32
) (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic [WIDTH-1:0] i_data,
   input wire logic i_valid,
   output logic o_ready,
   output logic [WIDTH-1:0] o_data,
   output logic o_valid,
   input wire logic i_ready
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr_r;
   logic [AW-1:0] rd_ptr_r;
   logic [AW:0] count_r;
   logic do_wr;
   logic do_rd;

   assign o_ready = (count_r != DEPTH[AW:0]);
   assign o_valid = (count_r != '0);
   assign o_data = mem[rd_ptr_r];
   assign do_wr = i_valid && o_ready;
   assign do_rd = o_valid && i_ready;

   always_ff @(posedge i_clk_sys) begin
      if (do_wr) begin
         mem[wr_ptr_r] <= i_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r <= '0;
      end else begin
         if (do_wr) begin
            wr_ptr_r <= wr_ptr_r + 1'b1;
         end
         if (do_rd) begin
            rd_ptr_r <= rd_ptr_r + 1'b1;
         end
         if (do_wr && !do_rd) begin
            count_r <= count_r + 1'b1;
         end else if (do_rd && !do_wr) begin
            count_r <= count_r - 1'b1;
         end
      end
   end
endmodule : otp_word_fifo

// *** rtl/otp_word_program_sequencer.sv ***
// Programmer that burns and verifies a 64K x 16 one-time programmable memory
//
// Overview of operation
// - Each program strobe is held low for 100 us, inside the 95 to 105 us window.
// - A session starts at address zero after raising core to 6.5 V and program voltage to 13.0 V.
// - The first pass gives every address exactly one strobe and reads nothing back.
// - In the verify pass a failing word gets up to 10 more strobes, each followed by a verify.
// - A word still failing after 10 extra strobes fails the whole part and is reported.
// - A verified word advances the address until every address has been checked.
// - Afterwards both supplies return to 5.0 V and every word is read back and compared.
// - Verify reads wait 150 ns after output enable and 130 ns for the bus to float after release.
// - Core supply rises no later than program voltage and program voltage falls no later than core.
`timescale 1ns/100ps
`include "otp_prog_defines.svh"
module otp_word_program_sequencer (
   input wire logic i_clk_sys,
   input wire logic i_arst_n,
   input wire logic i_start,
   input wire logic [15:0] i_src_data,
   input wire logic i_src_valid,
   output logic o_src_ready,
   input wire logic [15:0] i_mem_data,
   output logic [15:0] o_mem_addr,
   output logic [15:0] o_mem_data,
   output logic o_mem_data_oe_n,
   output logic o_chip_select_n,
   output logic o_output_enable_n,
   output logic o_program_strobe_n,
   output logic o_vcc_prog,
   output logic o_vpp_prog,
   output logic o_id_select_line,
   output logic o_busy,
   output logic o_done,
   output logic o_pass,
   output logic o_fail
);
   import otp_prog_pkg::*;

   prog_state_t state_r;
   pass_t pass_r;
   logic [`TIMER_W-1:0] timer_r;
   logic [3:0] retry_r;
   logic [15:0] addr_r;
   logic [15:0] din_s1_r;
   logic [15:0] din_s2_r;
   logic [15:0] word_r;
   logic word_ok_r;
   logic bad_r;
   logic fifo_valid;
   logic [15:0] fifo_data;
   logic fifo_pop;
   logic timer_done;
   logic last_addr;
   logic mismatch;

   // Source words are streamed three times; the feeder must repeat the image for each pass
   otp_word_fifo #(
      .WIDTH(16),
      .DEPTH(`FIFO_DEPTH)
   ) u_fifo (
      .i_clk_sys(i_clk_sys),
      .i_arst_n(i_arst_n),
      .i_data(i_src_data),
      .i_valid(i_src_valid),
      .o_ready(o_src_ready),
      .o_data(fifo_data),
      .o_valid(fifo_valid),
      .i_ready(fifo_pop)
   );

   assign timer_done = (timer_r == '0);
   assign last_addr = (addr_r == `ADDR_LAST);
   assign mismatch = (din_s2_r != word_r);

   // Pin data crosses into the clock domain through two flops
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         din_s1_r <= 16'h0000;
         din_s2_r <= 16'h0000;
      end else begin
         din_s1_r <= i_mem_data;
         din_s2_r <= din_s1_r;
      end
   end

   // Words are taken from the FIFO only at the start of each address
   always_comb begin
      fifo_pop = 1'b0;
      if (fifo_valid && timer_done) begin
         case (state_r)
            ST_P1_SETUP: fifo_pop = !word_ok_r;
            ST_VF_OE: fifo_pop = !word_ok_r;
            ST_RB_OE: fifo_pop = !word_ok_r;
            default: fifo_pop = 1'b0;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         word_r <= 16'h0000;
      end else if (fifo_pop) begin
         word_r <= fifo_data;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         state_r <= ST_IDLE;
         pass_r <= PASS_ONE;
         timer_r <= '0;
         retry_r <= 4'h0;
         addr_r <= `ADDR_FIRST;
         word_ok_r <= 1'b0;
         bad_r <= 1'b0;
      end else begin
         if (!timer_done) begin
            timer_r <= timer_r - 1'b1;
         end
         case (state_r)
            ST_IDLE: begin
               if (i_start) begin
                  addr_r <= `ADDR_FIRST;
                  bad_r <= 1'b0;
                  pass_r <= PASS_ONE;
                  timer_r <= `TIMER_W'(`SETUP_CYC);
                  state_r <= ST_PWR_VCC;
               end
            end
            ST_PWR_VCC: begin
               if (timer_done) begin
                  timer_r <= `TIMER_W'(`SETUP_CYC);
                  state_r <= ST_PWR_VPP;
               end
            end
            ST_PWR_VPP: begin
               if (timer_done) begin
                  word_ok_r <= 1'b0;
                  state_r <= ST_P1_SETUP;
               end
            end
            ST_P1_SETUP: begin
               if (fifo_pop) begin
                  word_ok_r <= 1'b1;
                  timer_r <= `TIMER_W'(`SETUP_CYC);
               end else if (word_ok_r && timer_done) begin
                  timer_r <= `TIMER_W'(`STROBE_CYC);
                  state_r <= ST_P1_STROBE;
               end
            end
            ST_P1_STROBE: begin
               if (timer_done) begin
                  timer_r <= `TIMER_W'(`SETUP_CYC);
                  state_r <= ST_P1_HOLD;
               end
            end
            ST_P1_HOLD: begin
               if (timer_done) begin
                  word_ok_r <= 1'b0;
                  addr_r <= addr_r + 1'b1;
                  if (last_addr) begin
                     pass_r <= PASS_VERIFY;
                     state_r <= ST_VF_OE;
                  end else begin
                     state_r <= ST_P1_SETUP;
                  end
               end
            end
            ST_VF_OE: begin
               if (fifo_pop) begin
                  word_ok_r <= 1'b1;
                  retry_r <= 4'h0;
                  timer_r <= `TIMER_W'(`SETUP_CYC + `OUTPUT_VALID_CYC + `SYNC_CYC);
               end else if (word_ok_r && timer_done) begin
                  timer_r <= `TIMER_W'(`OUTPUT_FLOAT_CYC);
                  state_r <= ST_VF_FLOAT;
                  if (!mismatch) begin
                     word_ok_r <= 1'b0;
                     addr_r <= addr_r + 1'b1;
                  end
               end
            end
            ST_VF_FLOAT: begin
               if (timer_done) begin
                  if (word_ok_r) begin
                     if (retry_r == `MAX_RETRY) begin
                        bad_r <= 1'b1;
                        timer_r <= `TIMER_W'(`SETUP_CYC);
                        state_r <= ST_PWR_DOWN;
                     end else begin
                        retry_r <= retry_r + 1'b1;
                        timer_r <= `TIMER_W'(`STROBE_CYC);
                        state_r <= ST_VF_STROBE;
                     end
                  end else if (addr_r == `ADDR_FIRST) begin
                     timer_r <= `TIMER_W'(`SETUP_CYC);
                     state_r <= ST_PWR_DOWN;
                  end else begin
                     state_r <= ST_VF_OE;
                  end
               end
            end
            ST_VF_STROBE: begin
               if (timer_done) begin
                  timer_r <= `TIMER_W'(`SETUP_CYC + `OUTPUT_VALID_CYC + `SYNC_CYC);
                  state_r <= ST_VF_OE;
               end
            end
            ST_PWR_DOWN: begin
               if (timer_done) begin
                  if (bad_r) begin
                     state_r <= ST_DONE;
                  end else begin
                     pass_r <= PASS_READBACK;
                     word_ok_r <= 1'b0;
                     addr_r <= `ADDR_FIRST;
                     state_r <= ST_RB_OE;
                  end
               end
            end
            ST_RB_OE: begin
               if (fifo_pop) begin
                  word_ok_r <= 1'b1;
                  timer_r <= `TIMER_W'(`OUTPUT_VALID_CYC + `SYNC_CYC);
               end else if (word_ok_r && timer_done) begin
                  if (mismatch) begin
                     bad_r <= 1'b1;
                  end
                  word_ok_r <= 1'b0;
                  addr_r <= addr_r + 1'b1;
                  timer_r <= `TIMER_W'(`OUTPUT_FLOAT_CYC);
                  state_r <= ST_RB_FLOAT;
               end
            end
            ST_RB_FLOAT: begin
               if (timer_done) begin
                  state_r <= (addr_r == `ADDR_FIRST) ? ST_DONE : ST_RB_OE;
               end
            end
            ST_DONE: begin
               if (!i_start) begin
                  state_r <= ST_IDLE;
               end
            end
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   // Pin drive, all registered
   always_ff @(posedge i_clk_sys or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_mem_addr <= 16'h0000;
         o_mem_data <= 16'h0000;
         o_mem_data_oe_n <= 1'b1;
         o_chip_select_n <= 1'b1;
         o_output_enable_n <= 1'b1;
         o_program_strobe_n <= 1'b1;
         o_vcc_prog <= 1'b0;
         o_vpp_prog <= 1'b0;
         o_id_select_line <= 1'b0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_pass <= 1'b0;
         o_fail <= 1'b0;
      end else begin
         o_mem_addr <= addr_r;
         o_mem_data <= word_r;
         // Id voltage never used while programming, so the strap stays low
         o_id_select_line <= 1'b0;
         o_vcc_prog <= (state_r != ST_IDLE) && (state_r != ST_DONE) && (pass_r != PASS_READBACK) &&
                       (state_r != ST_PWR_DOWN || o_vpp_prog);
         o_vpp_prog <= (state_r != ST_IDLE) && (state_r != ST_DONE) && (state_r != ST_PWR_VCC) &&
                       (state_r != ST_PWR_DOWN) && (pass_r != PASS_READBACK);
         o_program_strobe_n <= !((state_r == ST_P1_STROBE || state_r == ST_VF_STROBE) && !timer_done);
         o_mem_data_oe_n <= !(state_r == ST_P1_SETUP || state_r == ST_P1_STROBE || state_r == ST_P1_HOLD ||
                              state_r == ST_VF_STROBE);
         o_chip_select_n <= !(state_r == ST_P1_SETUP || state_r == ST_P1_STROBE || state_r == ST_P1_HOLD ||
                              state_r == ST_VF_STROBE || state_r == ST_VF_OE || state_r == ST_RB_OE);
         o_output_enable_n <= !((state_r == ST_VF_OE || state_r == ST_RB_OE) && word_ok_r);
         o_busy <= (state_r != ST_IDLE) && (state_r != ST_DONE);
         o_done <= (state_r == ST_DONE);
         o_pass <= (state_r == ST_DONE) && !bad_r;
         o_fail <= (state_r == ST_DONE) && bad_r;
      end
   end
endmodule : otp_word_program_sequencer
